/* ncd_pkg.sv */
// Purpose: constants and types for the node command decoder
// Assumes: 250 MHz pclk, frames arrive over a 4-pin serial link
// Notes: response fields follow the command frame layout, with source and destination swapped
// Summary of operation
// R1 - frame: id, source, destination, payload, MSB first
// R2 - id low 15 bits select; bit 15 flags
// R3 - unknown id answers unknown-command code
// R4 - ping: one request to destination, reply returned
// R5 - configure children from stored bitstream
// R6 - write acquisition mode register
// R7 - read acquisition mode register
// R8 - write settings for currently selected mode
// R9 - read mode settings register
// R10 - write action register: reset, start, stop
// R11 - read action register
// R12 - store trigger mask; masked triggers suppressed
// R13 - read trigger mask
// R14 - write SRAM at pointer, then increment
// R15 - read SRAM at pointer, then increment
// R16 - zero whole SRAM
// R17 - reset all configuration registers to defaults
// R18 - report node type
// R19 - report firmware and software version
// R20 - write converter control register
// R21 - reads return value in payload, flag set
package ncd_pkg;
  localparam int FRAME_W = 80;
  localparam int PAY_W = 32;
  localparam int ID_HI = 79;
  localparam int ID_LO = 64;
  localparam int SRC_HI = 63;
  localparam int SRC_LO = 48;
  localparam int DST_HI = 47;
  localparam int DST_LO = 32;
  localparam int RESP_FLAG = 15;
  localparam logic [14:0] CMD_PING = 15'h0001;
  localparam logic [14:0] CMD_CFG_KIDS = 15'h0002;
  localparam logic [14:0] CMD_MODE_WR = 15'h0003;
  localparam logic [14:0] CMD_MODE_RD = 15'h0004;
  localparam logic [14:0] CMD_SETT_WR = 15'h0005;
  localparam logic [14:0] CMD_SETT_RD = 15'h0006;
  localparam logic [14:0] CMD_ACT_WR = 15'h0007;
  localparam logic [14:0] CMD_ACT_RD = 15'h0008;
  localparam logic [14:0] CMD_MASK_WR = 15'h0009;
  localparam logic [14:0] CMD_MASK_RD = 15'h000a;
  localparam logic [14:0] CMD_SRAM_WR = 15'h000b;
  localparam logic [14:0] CMD_SRAM_RD = 15'h000c;
  localparam logic [14:0] CMD_SRAM_ZERO = 15'h000d;
  localparam logic [14:0] CMD_RESET = 15'h000f;
  localparam logic [14:0] CMD_NODE_TYPE = 15'h0010;
  localparam logic [14:0] CMD_VERSION = 15'h0011;
  localparam logic [14:0] CMD_TDC_WR = 15'h0101;
  localparam logic [14:0] CMD_TDC_RD = 15'h0102;
  localparam logic [15:0] CODE_BUSY = 16'h0000;
  localparam logic [15:0] CODE_UNKNOWN = 16'h7f04;
  localparam logic [15:0] CODE_TIMEOUT = 16'h7f05;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] SETT_RST = 32'h0000_0000;
  localparam logic [31:0] ACT_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] TDC_RST = 32'h0000_0000;
  localparam int MODE_N = 4;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_SETT = 8'h04;
  localparam logic [7:0] OFS_ACT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_TDC = 8'h10;
  localparam logic [7:0] OFS_PTR = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_VER = 8'h1c;
  localparam logic [7:0] OFS_TYPE = 8'h20;
  localparam int CLK_NS = 4;
  localparam int SRAM_ACC_NS = 12;
  localparam int SRAM_ACC_CYC = (SRAM_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam int PING_TO_NS = 4000;
  localparam int PING_TO_CYC = PING_TO_NS / CLK_NS;
  localparam int CFG_TO_MS = 100;
  localparam int CFG_TO_CYC_DEF = CFG_TO_MS * 1000000 / CLK_NS;
  typedef enum logic [3:0] {
    NCD_COINC_DETECT_UNIT_CTRL,
    NCD_COINC_UNIT_CTRL,
    NCD_DETECT_UNIT_CTRL,
    NCD_DETECTOR_BOARD,
    NCD_MUX_BOARD_CTRL
  } ncd_node_t;
endpackage

/* ncd_if.sv */
// Purpose: carrier between decoder core, serial link and SRAM port
// Assumes: all signals on pclk
// Notes: none
interface ncd_if #(parameter int AW = 18);
  logic frame_valid;
  logic [79:0] frame;
  logic [79:0] resp;
  logic sram_req;
  logic sram_we;
  logic [AW-1:0] sram_addr;
  logic [31:0] sram_wdata;
  logic sram_done;
  logic [31:0] sram_rdata;
  modport core(input frame_valid, frame, sram_done, sram_rdata,
    output resp, sram_req, sram_we, sram_addr, sram_wdata);
  modport spi(output frame_valid, frame, input resp);
  modport mem(input sram_req, sram_we, sram_addr, sram_wdata,
    output sram_done, sram_rdata);
endinterface

/* ncd_spi_rx.sv */
// Purpose: serial slave that collects command frames and returns responses
// Assumes: clock idles low, data sampled on rising edge, MSB first
// Notes: response loaded when select falls
module ncd_spi_rx
  import ncd_pkg::*;
(
  // system
  input wire logic pclk,
  input wire logic presetn,
  // core side
  ncd_if.spi lk,
  // pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic sclk_d;
    logic cs_d;
    logic [79:0] sh_in;
    logic [79:0] sh_out;
    logic [6:0] cnt;
    logic miso;
    logic fv;
  } ncd_spi_st_t;
  ncd_spi_st_t r, n;
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.fv = 1'b0;
    n.s1 = {spi_sclk, spi_cs_n, spi_mosi};
    n.s2 = r.s1;
    n.sclk_d = r.s2[2];
    n.cs_d = r.s2[1];
    if (r.cs_d && !r.s2[1]) begin
      n.sh_out = lk.resp;
      n.miso = lk.resp[FRAME_W-1];
      n.cnt = 7'h00;
    end else if (!r.s2[1]) begin
      if (r.s2[2] && !r.sclk_d) begin
        n.sh_in = {r.sh_in[FRAME_W-2:0], r.s2[0]}; // [R1]
        if (r.cnt != 7'(FRAME_W)) begin
          n.cnt = r.cnt + 7'h01;
        end
      end
      if (!r.s2[2] && r.sclk_d) begin
        n.sh_out = {r.sh_out[FRAME_W-2:0], 1'b0};
        n.miso = r.sh_out[FRAME_W-2];
      end
    end
    if (!r.cs_d && r.s2[1] && r.cnt == 7'(FRAME_W)) begin
      n.fv = 1'b1; // [R1]
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{s1: 3'h2, s2: 3'h2, cs_d: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end
  assign lk.frame_valid = r.fv;
  assign lk.frame = r.sh_in;
  assign spi_miso = r.miso;
endmodule

/* ncd_sram_ctl.sv */
// Purpose: single-word access port for external asynchronous SRAM
// Assumes: read data settles within the access time
// Notes: read data passes two flops before capture
module ncd_sram_ctl
  import ncd_pkg::*;
#(
  parameter int AW = 18
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // core side
  ncd_if.mem lk,
  // pins
  output logic [AW-1:0] sram_addr,
  output logic [31:0] sram_dq_out,
  output logic sram_dq_oe,
  input wire logic [31:0] sram_dq_in,
  output logic sram_ce_n,
  output logic sram_we_n,
  output logic sram_oe_n
);
  typedef enum logic [1:0] {S_IDLE, S_ACC, S_SYNC} ncd_mst_t;
  typedef struct packed {
    ncd_mst_t st;
    logic [3:0] cnt;
    logic [AW-1:0] addr;
    logic [31:0] dq;
    logic oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [31:0] d1;
    logic [31:0] d2;
    logic done;
    logic [31:0] rdata;
  } ncd_mem_st_t;
  ncd_mem_st_t r, n;
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.d1 = sram_dq_in;
    n.d2 = r.d1;
    n.cnt = r.cnt + 4'h1;
    unique case (r.st)
      S_IDLE: begin
        if (lk.sram_req) begin
          n.addr = lk.sram_addr;
          n.dq = lk.sram_wdata;
          n.oe = lk.sram_we;
          n.ce_n = 1'b0;
          n.we_n = !lk.sram_we;
          n.oe_n = lk.sram_we;
          n.cnt = 4'h0;
          n.st = S_ACC;
        end
      end
      S_ACC: begin
        if (r.cnt == 4'(SRAM_ACC_CYC - 1)) begin
          n.cnt = 4'h0;
          if (r.oe) begin
            n.ce_n = 1'b1;
            n.we_n = 1'b1;
            n.oe = 1'b0;
            n.done = 1'b1;
            n.st = S_IDLE;
          end else begin
            n.st = S_SYNC;
          end
        end
      end
      S_SYNC: begin
        if (r.cnt == 4'(SYNC_CYC - 1)) begin
          n.rdata = r.d2;
          n.ce_n = 1'b1;
          n.oe_n = 1'b1;
          n.done = 1'b1;
          n.st = S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: S_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end
  assign lk.sram_done = r.done;
  assign lk.sram_rdata = r.rdata;
  assign sram_addr = r.addr;
  assign sram_dq_out = r.dq;
  assign sram_dq_oe = r.oe;
  assign sram_ce_n = r.ce_n;
  assign sram_we_n = r.we_n;
  assign sram_oe_n = r.oe_n;
endmodule

/* ncd_top.sv */
// Purpose: command decoder for one node of an acquisition tree
// Assumes: parent waits for a reply before the next command
// Notes: software sees the same registers over APB
module ncd_top
  import ncd_pkg::*;
#(
  parameter int SRAM_AW = 18,
  parameter int TRIG_N = 32,
  parameter logic IS_SUPPORT = 1'b1,
  parameter ncd_pkg::ncd_node_t NODE_TYPE = ncd_pkg::NCD_DETECT_UNIT_CTRL,
  parameter logic [15:0] FW_VER = 16'h0001, // arbitrary value
  parameter logic [15:0] SW_VER = 16'h0001, // arbitrary value
  parameter int CFG_TO_CYC = ncd_pkg::CFG_TO_CYC_DEF
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // parent link
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // child requests
  output logic ping_req,
  output logic [15:0] ping_dst,
  input wire logic ping_ack,
  input wire logic [31:0] ping_reply,
  output logic cfg_start,
  input wire logic cfg_done,
  // acquisition
  input wire logic [TRIG_N-1:0] trig_in,
  output logic [TRIG_N-1:0] trig_out,
  output logic [31:0] acq_mode,
  output logic [31:0] acq_settings,
  output logic [31:0] acq_action,
  output logic [31:0] tdc_ctrl,
  // sram pins
  output logic [SRAM_AW-1:0] sram_addr,
  output logic [31:0] sram_dq_out,
  output logic sram_dq_oe,
  input wire logic [31:0] sram_dq_in,
  output logic sram_ce_n,
  output logic sram_we_n,
  output logic sram_oe_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_SRAM, ST_ZERO, ST_PING, ST_CFG} ncd_st_t;
  typedef struct packed {
    ncd_st_t st;
    logic [31:0] mode;
    logic [MODE_N-1:0][31:0] sett;
    logic [31:0] cur_sett;
    logic [31:0] act;
    logic [31:0] mask;
    logic [31:0] tdc;
    logic [SRAM_AW-1:0] ptr;
    logic [14:0] ccmd;
    logic [15:0] csrc;
    logic [15:0] cdst;
    logic [79:0] resp;
    logic [31:0] cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ping_req;
    logic [15:0] ping_dst;
    logic cfg_start;
    logic sram_req;
    logic sram_we;
    logic [31:0] sram_wdata;
    logic ack_s1;
    logic ack_s2;
    logic done_s1;
    logic done_s2;
    logic [31:0] rep_s1;
    logic [31:0] rep_s2;
    logic [TRIG_N-1:0] trg_s1;
    logic [TRIG_N-1:0] trg_s2;
    logic [TRIG_N-1:0] trig_out;
  } ncd_core_st_t;
  ncd_core_st_t r, n;
  ncd_if #(.AW(SRAM_AW)) lk();
  //////////////////////////////////////////////////////////////////////////////
  ncd_spi_rx u_spi (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk.spi),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso)
  );
  ncd_sram_ctl #(.AW(SRAM_AW)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk.mem),
    .sram_addr(sram_addr),
    .sram_dq_out(sram_dq_out),
    .sram_dq_oe(sram_dq_oe),
    .sram_dq_in(sram_dq_in),
    .sram_ce_n(sram_ce_n),
    .sram_we_n(sram_we_n),
    .sram_oe_n(sram_oe_n)
  );
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic fin;
    logic [15:0] code;
    logic [31:0] pay;
    logic [31:0] fpay;
    logic [7:0] ofs;
    fin = 1'b0;
    code = 16'h0000;
    pay = 32'h0000_0000;
    fpay = lk.frame[PAY_W-1:0];
    ofs = paddr;
    n = r;
    n.pready = 1'b0;
    n.ping_req = 1'b0;
    n.cfg_start = 1'b0;
    n.sram_req = 1'b0;
    n.ack_s1 = ping_ack;
    n.ack_s2 = r.ack_s1;
    n.done_s1 = cfg_done;
    n.done_s2 = r.done_s1;
    n.rep_s1 = ping_reply;
    n.rep_s2 = r.rep_s1;
    n.trg_s1 = trig_in;
    n.trg_s2 = r.trg_s1;
    n.trig_out = r.trg_s2 & ~r.mask[TRIG_N-1:0]; // [R12]
    n.cnt = r.cnt + 32'h1;
    unique case (r.st)
      ST_IDLE: begin
        if (lk.frame_valid) begin
          n.ccmd = lk.frame[ID_HI-1:ID_LO]; // [R2]
          n.csrc = lk.frame[SRC_HI:SRC_LO];
          n.cdst = lk.frame[DST_HI:DST_LO];
          n.resp = {CODE_BUSY, 64'h0};
          n.cnt = 32'h0;
          fin = 1'b1;
          case (lk.frame[ID_HI-1:ID_LO])
            CMD_PING: begin
              fin = 1'b0;
              n.ping_req = 1'b1; // [R4]
              n.ping_dst = lk.frame[DST_HI:DST_LO];
              n.st = ST_PING;
            end
            CMD_CFG_KIDS: begin
              if (IS_SUPPORT) begin
                fin = 1'b0;
                n.cfg_start = 1'b1; // [R5]
                n.st = ST_CFG;
              end else begin
                code = CODE_UNKNOWN; // [R3]
              end
            end
            CMD_MODE_WR: begin
              n.mode = fpay; // [R6]
              pay = fpay;
            end
            CMD_MODE_RD: pay = r.mode; // [R7]
            CMD_SETT_WR: begin
              n.sett[r.mode[1:0]] = fpay; // [R8]
              pay = fpay;
            end
            CMD_SETT_RD: pay = r.sett[r.mode[1:0]]; // [R9]
            CMD_ACT_WR: begin
              n.act = fpay; // [R10]
              pay = fpay;
            end
            CMD_ACT_RD: pay = r.act; // [R11]
            CMD_MASK_WR: begin
              n.mask = fpay; // [R12]
              pay = fpay;
            end
            CMD_MASK_RD: pay = r.mask; // [R13]
            CMD_SRAM_WR, CMD_SRAM_RD: begin
              fin = 1'b0;
              n.sram_req = 1'b1; // [R14] [R15]
              n.sram_we = (lk.frame[ID_HI-1:ID_LO] == CMD_SRAM_WR);
              n.sram_wdata = fpay;
              n.st = ST_SRAM;
            end
            CMD_SRAM_ZERO: begin
              fin = 1'b0;
              n.ptr = '0;
              n.sram_req = 1'b1; // [R16]
              n.sram_we = 1'b1;
              n.sram_wdata = 32'h0000_0000;
              n.st = ST_ZERO;
            end
            CMD_RESET: begin
              n.mode = MODE_RST; // [R17]
              n.sett = {MODE_N{SETT_RST}};
              n.act = ACT_RST;
              n.mask = MASK_RST;
              n.tdc = TDC_RST;
              n.ptr = '0;
            end
            CMD_NODE_TYPE: pay = 32'(NODE_TYPE); // [R18]
            CMD_VERSION: pay = {FW_VER, SW_VER}; // [R19]
            CMD_TDC_WR: begin
              n.tdc = fpay; // [R20]
              pay = fpay;
            end
            CMD_TDC_RD: pay = r.tdc;
            default: code = CODE_UNKNOWN; // [R3]
          endcase
        end
      end
      ST_SRAM: begin
        if (lk.sram_done) begin
          fin = 1'b1;
          pay = r.sram_we ? r.sram_wdata : lk.sram_rdata; // [R15]
          n.ptr = r.ptr + 1'b1; // [R14] [R15]
        end
      end
      ST_ZERO: begin
        if (lk.sram_done) begin
          if (&r.ptr) begin
            fin = 1'b1;
            n.ptr = '0;
          end else begin
            n.ptr = r.ptr + 1'b1; // [R16]
            n.sram_req = 1'b1;
          end
        end
      end
      ST_PING: begin
        if (r.ack_s2) begin
          fin = 1'b1;
          pay = r.rep_s2; // [R4]
        end else if (r.cnt == 32'(PING_TO_CYC)) begin
          fin = 1'b1;
          code = CODE_TIMEOUT;
        end
      end
      ST_CFG: begin
        if (r.done_s2) begin
          fin = 1'b1; // [R5]
        end else if (r.cnt == 32'(CFG_TO_CYC)) begin
          fin = 1'b1;
          code = CODE_TIMEOUT;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (fin) begin
      if (code == 16'h0000) begin
        code = {1'b0, n.ccmd};
      end
      code[RESP_FLAG] = 1'b1; // [R2] [R21]
      n.resp = {code, n.cdst, n.csrc, pay}; // [R21]
      n.st = ST_IDLE;
    end
    // apb: answer registered in setup, write taken in access
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = 32'h0000_0000;
      case (ofs)
        OFS_MODE: n.prdata = r.mode;
        OFS_SETT: n.prdata = r.cur_sett;
        OFS_ACT: n.prdata = r.act;
        OFS_MASK: n.prdata = r.mask;
        OFS_TDC: n.prdata = r.tdc;
        OFS_PTR: n.prdata = 32'(r.ptr);
        OFS_STAT: n.prdata = {16'h0, r.st != ST_IDLE, r.ccmd};
        OFS_VER: n.prdata = {FW_VER, SW_VER};
        OFS_TYPE: n.prdata = 32'(NODE_TYPE);
        default: n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && r.pready && pwrite && !r.pslverr) begin
      case (ofs)
        OFS_MODE: n.mode = pwdata;
        OFS_SETT: n.sett[n.mode[1:0]] = pwdata;
        OFS_ACT: n.act = pwdata;
        OFS_MASK: n.mask = pwdata;
        OFS_TDC: n.tdc = pwdata;
        OFS_PTR: n.ptr = pwdata[SRAM_AW-1:0];
        default: n.pready = 1'b0;
      endcase
    end
    n.cur_sett = n.sett[n.mode[1:0]];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: ST_IDLE, mode: MODE_RST, sett: {MODE_N{SETT_RST}}, cur_sett: SETT_RST,
        act: ACT_RST, mask: MASK_RST, tdc: TDC_RST, default: '0};
    end else begin
      r <= n;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  assign lk.resp = r.resp;
  assign lk.sram_req = r.sram_req;
  assign lk.sram_we = r.sram_we;
  assign lk.sram_addr = r.ptr;
  assign lk.sram_wdata = r.sram_wdata;
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign ping_req = r.ping_req;
  assign ping_dst = r.ping_dst;
  assign cfg_start = r.cfg_start;
  assign trig_out = r.trig_out;
  assign acq_mode = r.mode;
  assign acq_settings = r.cur_sett;
  assign acq_action = r.act;
  assign tdc_ctrl = r.tdc;
endmodule

/* ncd_top_properties.sv */
// Purpose: port assertions for the node command decoder
// Assumes: apb answers in the first access cycle
// Notes: bound into every ncd_top
module ncd_top_chk
  import ncd_pkg::*;
#(
  parameter int SRAM_AW = 18
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // children and registers
  input wire logic ping_req,
  input wire logic [15:0] ping_dst,
  input wire logic cfg_start,
  input wire logic [31:0] acq_mode,
  // sram
  input wire logic [SRAM_AW-1:0] sram_addr,
  input wire logic sram_dq_oe,
  input wire logic sram_ce_n,
  input wire logic sram_we_n,
  input wire logic sram_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb answer missing");
  chk_mode_read: assert property (pready && psel && !pwrite && paddr == OFS_MODE
    |-> prdata == acq_mode) else $error("mode read wrong");
  chk_mode_write: assert property (pready && psel && pwrite && paddr == OFS_MODE
    |=> acq_mode == $past(pwdata)) else $error("mode write lost");
  chk_ping_pulse: assert property (ping_req |=> !ping_req)
    else $error("ping request repeated");
  chk_ping_dst: assert property (ping_req |=> $stable(ping_dst))
    else $error("ping destination moved");
  chk_cfg_pulse: assert property (cfg_start |=> !cfg_start)
    else $error("config start repeated");
  chk_write_drive: assert property (!sram_we_n |-> sram_oe_n && !sram_ce_n && sram_dq_oe)
    else $error("sram write strobes wrong");
  chk_read_float: assert property (!sram_oe_n |-> !sram_dq_oe && !sram_ce_n)
    else $error("sram read while driving");
  chk_write_len: assert property ($fell(sram_we_n) |-> (!sram_we_n)[*3])
    else $error("sram write too short");
  chk_addr_hold: assert property ($fell(sram_we_n) |=> $stable(sram_addr)[*2])
    else $error("sram address moved");
  chk_read_len: assert property ($fell(sram_oe_n) |-> (!sram_oe_n)[*3])
    else $error("sram read too short");
endmodule
////////////////////////////////////////
bind ncd_top ncd_top_chk #(.SRAM_AW(SRAM_AW)) u_ncd_top_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .ping_req, .ping_dst, .cfg_start,
  .acq_mode, .sram_addr, .sram_dq_oe, .sram_ce_n, .sram_we_n, .sram_oe_n);

/* ncd_parent.sv */
// Purpose: parent node model driving the command link
// Assumes: sclk idles low, half period six pclk
// Notes: each frame returns the previous response
module ncd_parent (
  // system
  input wire logic pclk,
  // link
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [79:0] rx = 80'h0;
  event got;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  ////////////////////////////////////////
  // one frame out msb first, last response in
  task automatic xfer(input logic [79:0] c);
    spi_cs_n <= 1'b0;
    repeat (6) @(posedge pclk);
    for (int i = 79; i >= 0; i--) begin
      spi_mosi <= c[i];
      repeat (6) @(posedge pclk);
      spi_sclk <= 1'b1;
      rx[i] = spi_miso;
      repeat (6) @(posedge pclk);
      spi_sclk <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~c[0];
    -> got;
    repeat (300) @(posedge pclk);
  endtask
endmodule

/* tb.sv */
// Purpose: self-checking bench for the node command decoder
// Assumes: bench is apb master, child, sram and trigger source
// Notes: link responses are checked one frame late
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ncd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, ping_reply = 32'h0, trig_in = 32'h0, sram_dq_in = 32'h0;
  logic ping_ack = 1'b0, cfg_done = 1'b0, pready, pslverr, spi_sclk, spi_cs_n, spi_mosi;
  logic spi_miso, ping_req, cfg_start, sram_dq_oe, sram_ce_n, sram_we_n, sram_oe_n;
  logic [31:0] prdata, trig_out, sram_dq_out, acq_settings, acq_action, tdc_ctrl;
  logic mute = 1'b0;
  logic [15:0] ping_dst;
  logic [3:0] sram_addr;
  logic [31:0] mem [16];
  logic [31:0] r [8];
  logic [80:0] aq[$], lq[$];
  int errors = 0, checked = 0, nfr = 0;
  // version values arbitrary
  ncd_top #(.SRAM_AW(4), .NODE_TYPE(NCD_DETECTOR_BOARD), .FW_VER(16'h00a5),
    .SW_VER(16'h005a), .CFG_TO_CYC(200)) u_ncd_top (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .spi_sclk, .spi_cs_n, .spi_mosi,
    .spi_miso, .ping_req, .ping_dst, .ping_ack, .ping_reply, .cfg_start, .cfg_done,
    .trig_in, .trig_out, .acq_mode(), .acq_settings, .acq_action, .tdc_ctrl,
    .sram_addr, .sram_dq_out, .sram_dq_oe, .sram_dq_in, .sram_ce_n, .sram_we_n, .sram_oe_n);
  ncd_parent u_ncd_parent (.pclk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  always #2 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic cmp(input string n, input logic [80:0] e, input logic [79:0] v);
    checked++;
    if (v[79:64] !== e[79:64] || (e[80] && v !== e[79:0])) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e[79:0], v);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    aq.push_back({1'b1, 47'h0, e, w ? 32'h0 : d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic lnk(input logic [14:0] id, input logic [31:0] p, input logic f,
      input logic [31:0] rp);
    logic [14:0] rid;
    rid = (id == 15'h0055) ? CODE_UNKNOWN[14:0] : mute ? CODE_TIMEOUT[14:0] : id;
    lq.push_back({f, 1'b1, rid, 16'h0201, 16'h4000, rp});
    u_ncd_parent.xfer({1'b0, id, 16'h4000, 16'h0201, p});
  endtask
  ////////////////////////////////////////
  // result monitors
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      cmp("apb", aq.pop_front(), {47'h0, pslverr, pwrite ? 32'h0 : prdata});
    end
  end
  always @(u_ncd_parent.got) begin
    if (nfr > 0) begin
      cmp("response", lq.pop_front(), u_ncd_parent.rx);
    end
    nfr++;
  end
  // child, config and sram partners
  initial forever begin
    do @(posedge pclk); while (ping_req !== 1'b1);
    cmp("ping_dst", aq.pop_front(), {64'h0, ping_dst});
    repeat (10) @(posedge pclk);
    ping_reply <= r[7];
    ping_ack <= 1'b1;
    repeat (10) @(posedge pclk);
    ping_ack <= 1'b0;
    ping_reply <= ~r[7];
  end
  initial forever begin
    do @(posedge pclk); while (cfg_start !== 1'b1);
    repeat (10) @(posedge pclk);
    cfg_done <= !mute;
    repeat (10) @(posedge pclk);
    cfg_done <= 1'b0;
  end
  always @(posedge pclk) begin
    if (!sram_ce_n && !sram_we_n && sram_dq_oe) begin
      mem[sram_addr] <= sram_dq_out;
    end
    if (!sram_ce_n && !sram_oe_n) begin
      sram_dq_in <= mem[sram_addr];
    end else begin
      sram_dq_in <= ~sram_dq_in;
    end
  end
  initial begin
    #300us;
    errors++;
    test_done;
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(73937));
    foreach (r[i]) r[i] = $urandom;
    r[0] = {30'h0, r[0][1:0]};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    lnk(CMD_MODE_WR, r[0], 1'b1, r[0]);
    lnk(CMD_SETT_WR, r[1], 1'b1, r[1]);
    lnk(CMD_MODE_RD, 32'h0, 1'b1, r[0]);
    lnk(CMD_SETT_RD, 32'h0, 1'b1, r[1]);
    cmp("acq_settings", {1'b1, 48'h0, r[1]}, {48'h0, acq_settings});
    lnk(CMD_MODE_WR, r[0] ^ 32'h1, 1'b1, r[0] ^ 32'h1);
    lnk(CMD_SETT_RD, 32'h0, 1'b1, SETT_RST);
    lnk(CMD_ACT_WR, r[2], 1'b1, r[2]);
    lnk(CMD_ACT_RD, 32'h0, 1'b1, r[2]);
    cmp("acq_action", {1'b1, 48'h0, r[2]}, {48'h0, acq_action});
    lnk(CMD_MASK_WR, r[3], 1'b1, r[3]);
    lnk(CMD_MASK_RD, 32'h0, 1'b1, r[3]);
    trig_in <= r[4];
    repeat (8) @(posedge pclk);
    cmp("trig_out", {1'b1, 48'h0, r[4] & ~r[3]}, {48'h0, trig_out});
    lnk(CMD_TDC_WR, r[5], 1'b1, r[5]);
    cmp("tdc_ctrl", {1'b1, 48'h0, r[5]}, {48'h0, tdc_ctrl});
    lnk(CMD_TDC_RD, 32'h0, 1'b1, r[5]);
    apb(1'b0, OFS_TDC, r[5], 1'b0);
    apb(1'b0, OFS_MODE, r[0] ^ 32'h1, 1'b0);
    apb(1'b1, OFS_MODE, r[0], 1'b0);
    apb(1'b0, OFS_MODE, r[0], 1'b0);
    apb(1'b1, 8'h40, r[1], 1'b1);
    apb(1'b1, OFS_PTR, 32'h2, 1'b0);
    lnk(CMD_SRAM_WR, r[6], 1'b1, r[6]);
    lnk(CMD_SRAM_WR, r[7], 1'b1, r[7]);
    apb(1'b0, OFS_PTR, 32'h4, 1'b0);
    cmp("sram", {1'b1, 48'h0, r[6]}, {48'h0, mem[2]});
    apb(1'b1, OFS_PTR, 32'h2, 1'b0);
    lnk(CMD_SRAM_RD, 32'h0, 1'b1, r[6]);
    lnk(CMD_SRAM_RD, 32'h0, 1'b1, r[7]);
    lnk(CMD_SRAM_ZERO, 32'h0, 1'b0, 32'h0);
    apb(1'b1, OFS_PTR, 32'h3, 1'b0);
    lnk(CMD_SRAM_RD, 32'h0, 1'b1, 32'h0);
    aq.push_back({1'b1, 64'h0, 16'h0201});
    lnk(CMD_PING, 32'h0, 1'b1, r[7]);
    lnk(CMD_CFG_KIDS, 32'h0, 1'b0, 32'h0);
    mute = 1'b1;
    lnk(CMD_CFG_KIDS, 32'h0, 1'b0, 32'h0);
    mute = 1'b0;
    lnk(15'h0055, r[1], 1'b0, 32'h0);
    lnk(CMD_VERSION, 32'h0, 1'b1, {16'h00a5, 16'h005a});
    lnk(CMD_NODE_TYPE, 32'h0, 1'b1, {28'h0, NCD_DETECTOR_BOARD});
    lnk(CMD_RESET, 32'h0, 1'b0, 32'h0);
    lnk(CMD_MODE_RD, 32'h0, 1'b1, MODE_RST);
    apb(1'b0, OFS_MASK, MASK_RST, 1'b0);
    apb(1'b0, OFS_ACT, ACT_RST, 1'b0);
    u_ncd_parent.xfer({1'b0, CMD_MODE_RD, 16'h4000, 16'h0201, 32'h0});
    test_done;
  end
endmodule
